// [csfod_pkg.sv]
// Package for the CPU status flags and opcode decode block.
// Holds bit positions, register indices, opcode values and condition encodings.
package csfod_pkg;

   // Status register bit positions
   localparam int unsigned FLAG_C   = 7;
   localparam int unsigned FLAG_Z   = 6;
   localparam int unsigned FLAG_S   = 5;
   localparam int unsigned FLAG_V   = 4;
   localparam int unsigned FLAG_D   = 3;
   localparam int unsigned FLAG_H   = 2;
   localparam int unsigned FLAG_U2  = 1;
   localparam int unsigned FLAG_U1  = 0;

   // Condition bits cleared by reset; user bits are not touched
   localparam logic [5:0] COND_RESET = 6'h00;

   // Register indices on the plain register port
   localparam logic [3:0] REG_FLAGS   = 4'h0;
   localparam logic [3:0] REG_DECODE  = 4'h1;
   localparam logic [3:0] REG_LAST_OP = 4'h2;

   // First-map opcode values
   localparam logic [7:0] OP_BREAKPOINT = 8'h00;
   localparam logic [7:0] OP_NO_OP      = 8'h0F;
   localparam logic [7:0] OP_ESCAPE     = 8'h1F;
   localparam logic [7:0] OP_ATOMIC     = 8'h2F;
   localparam logic [7:0] OP_WATCHDOG   = 8'h5F;
   localparam logic [7:0] OP_STOP       = 8'h6F;
   localparam logic [7:0] OP_HALT       = 8'h7F;

   // Columns whose upper nibble carries a register or condition field
   localparam logic [3:0] COL_DEC_JUMP  = 4'hA;
   localparam logic [3:0] COL_REL_JUMP  = 4'hB;
   localparam logic [3:0] COL_ABS_JUMP  = 4'hD;

   // Condition codes: bit 3 inverts the base test selected by bits 2:0
   localparam logic [2:0] CC_NEVER = 3'h0;
   localparam logic [2:0] CC_LT    = 3'h1;
   localparam logic [2:0] CC_LE    = 3'h2;
   localparam logic [2:0] CC_ULE   = 3'h3;
   localparam logic [2:0] CC_OV    = 3'h4;
   localparam logic [2:0] CC_MI    = 3'h5;
   localparam logic [2:0] CC_EQ    = 3'h6;
   localparam logic [2:0] CC_CY    = 3'h7;

   // Save cause codes
   localparam logic [1:0] CAUSE_NONE    = 2'h0;
   localparam logic [1:0] CAUSE_IRQ     = 2'h1;
   localparam logic [1:0] CAUSE_TRAP    = 2'h2;
   localparam logic [1:0] CAUSE_ILLEGAL = 2'h3;

   typedef enum logic [3:0] {
      CSFOD_DEC_NONE,
      CSFOD_DEC_OTHER,
      CSFOD_DEC_BREAKPOINT,
      CSFOD_DEC_NO_OP,
      CSFOD_DEC_ATOMIC,
      CSFOD_DEC_WATCHDOG,
      CSFOD_DEC_STOP,
      CSFOD_DEC_HALT,
      CSFOD_DEC_ESCAPE,
      CSFOD_DEC_MAP2
   } csfod_dec_t;

   typedef enum logic {
      CSFOD_MAP_FIRST,
      CSFOD_MAP_SECOND
   } csfod_map_t;

endpackage

// [csfod_cond_if.sv]
// Interface between the main block and its condition evaluator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface csfod_cond_if;
   logic [3:0] code;
   logic [7:0] flags;
   logic       result;

   modport evaluator (input code, input flags, output result);
   modport requester (output code, output flags, input result);
endinterface
`default_nettype wire

// [csfod_cond_eval.sv]
// Condition evaluator: tests carry, overflow, zero and sign for jumps.
// Assumes flags arrive in status-register layout; result is registered.
`timescale 1ns/1ps
`default_nettype none
module csfod_cond_eval
   import csfod_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   csfod_cond_if.evaluator    cond
);

   logic fc;
   logic fz;
   logic fs;
   logic fv;
   logic base_hit;
   logic result_nxt;
   logic result_r;

   // Only C, Z, S and V are tapped; H, D and user bits never reach a test
   assign fc = cond.flags[FLAG_C];
   assign fz = cond.flags[FLAG_Z];
   assign fs = cond.flags[FLAG_S];
   assign fv = cond.flags[FLAG_V];

   always_comb begin
      case (cond.code[2:0])
         CC_NEVER: base_hit = 1'b0;
         CC_LT:    base_hit = fs ^ fv;
         CC_LE:    base_hit = fz | (fs ^ fv);
         CC_ULE:   base_hit = fc | fz;
         CC_OV:    base_hit = fv;
         CC_MI:    base_hit = fs;
         CC_EQ:    base_hit = fz;
         CC_CY:    base_hit = fc;
         default:  base_hit = 1'b0;
      endcase
   end

   assign result_nxt = base_hit ^ cond.code[3];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         result_r <= 1'b0;
      end else begin
         result_r <= result_nxt;
      end
   end

   assign cond.result = result_r;

endmodule
`default_nettype wire

// [csfod_core.sv]
// Status flags register and first-level opcode decoder of an 8-bit CPU.
// Assumes all inputs are synchronous to ref_clk and strobes are one cycle.
//
// Notes on behaviour
// - Flags follow the latest arithmetic, logic, bit or shift result.
// - Six condition bits plus two general-purpose user bits.
// - Jump conditions can test carry, overflow, zero and sign.
// - Half-carry and decimal bits serve BCD only; never a jump condition.
// - User bits change only by explicit instruction, never by arithmetic.
// - No condition encoding tests either user bit.
// - User bits power up undefined and reset leaves them alone.
// - Interrupt, software trap and illegal trap push the flags.
// - Interrupt return reloads flags from the stacked value.
// - Displacement operand is an 8-bit two's-complement signed value.
// - First byte 1F escapes; next byte uses the second map.
`timescale 1ns/1ps
`default_nettype none
module csfod_core
   import csfod_pkg::*;
#(
   parameter int unsigned DISP_W = 16
)(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // Flag results from the execution unit
   input  wire logic              alu_flag_we,
   input  wire logic [5:0]        alu_flag_mask,
   input  wire logic [5:0]        alu_flag_val,
   // Explicit user bit instruction
   input  wire logic              user_bit_we,
   input  wire logic              user_bit_sel,
   input  wire logic              user_bit_val,
   // Save and restore around exceptions
   input  wire logic              save_irq,
   input  wire logic              save_trap,
   input  wire logic              save_illegal,
   output logic                   stack_push_valid,
   output logic [7:0]             stack_push_data,
   output logic [1:0]             stack_push_cause,
   input  wire logic              interrupt_return_instruction,
   input  wire logic [7:0]        stack_pop_data,
   // Condition query
   input  wire logic [3:0]        cond_code,
   output logic                   cond_true,
   // Opcode stream
   input  wire logic              op_valid,
   input  wire logic [7:0]        op_byte,
   input  wire logic              disp_valid,
   input  wire logic [7:0]        disp_byte,
   // Decode results
   output logic [7:0]             flags,
   output logic                   dec_valid,
   output logic [3:0]             dec_row,
   output logic [3:0]             dec_col,
   output logic [3:0]             dec_class,
   output logic                   dec_second_map,
   output logic                   dec_uses_cc,
   output logic                   disp_out_valid,
   output logic [DISP_W-1:0]      disp_out
);

   // Condition bits live in their own register; each user bit has a register of its own
   logic [5:0]        cond_bits_r;
   logic [5:0]        cond_bits_nxt;
   logic              user_one_r;
   logic              user_one_nxt;
   logic              user_two_r;
   logic              user_two_nxt;
   logic [7:0]        flags_now;
   // Explicit user-bit write decodes
   logic              user_one_set;
   logic              user_two_set;

   logic [7:0]        reg_rdata_r;
   logic [7:0]        reg_rdata_nxt;

   logic              push_valid_r;
   logic [7:0]        push_data_r;
   logic [1:0]        push_cause_r;
   logic              save_any;
   logic [1:0]        save_cause;

   csfod_map_t        map_r;
   csfod_map_t        map_nxt;
   csfod_dec_t        class_r;
   csfod_dec_t        class_nxt;
   logic              dec_valid_r;
   logic [3:0]        dec_row_r;
   logic [3:0]        dec_col_r;
   logic              dec_second_r;
   logic              dec_uses_cc_r;
   logic              dec_uses_cc_nxt;
   logic [7:0]        last_op_r;

   logic              disp_valid_r;
   logic [DISP_W-1:0] disp_r;
   logic [DISP_W-1:0] disp_nxt;

   logic              sw_flags_wr;
   logic              is_cc_jump;
   logic [3:0]        cc_select;

   csfod_cond_if      cond_bus ();

   // Assemble the architectural flags byte
   always_comb begin
      flags_now          = 8'h00;
      flags_now[FLAG_C]  = cond_bits_r[5];
      flags_now[FLAG_Z]  = cond_bits_r[4];
      flags_now[FLAG_S]  = cond_bits_r[3];
      flags_now[FLAG_V]  = cond_bits_r[2];
      flags_now[FLAG_D]  = cond_bits_r[1];
      flags_now[FLAG_H]  = cond_bits_r[0];
      flags_now[FLAG_U2] = user_two_r;
      flags_now[FLAG_U1] = user_one_r;
   end

   assign sw_flags_wr = reg_wr && (reg_addr == REG_FLAGS);

   // Condition bits: restore beats software write beats execution result.
   // Execution updates only the bits its mask names; the rest hold.
   always_comb begin
      cond_bits_nxt = (cond_bits_r & ~alu_flag_mask) | (alu_flag_val & alu_flag_mask);
      if (!alu_flag_we) begin
         cond_bits_nxt = cond_bits_r;
      end
      if (sw_flags_wr) begin
         cond_bits_nxt = {reg_wdata[FLAG_C], reg_wdata[FLAG_Z], reg_wdata[FLAG_S],
                          reg_wdata[FLAG_V], reg_wdata[FLAG_D], reg_wdata[FLAG_H]};
      end
      if (interrupt_return_instruction) begin
         cond_bits_nxt = {stack_pop_data[FLAG_C], stack_pop_data[FLAG_Z],
                          stack_pop_data[FLAG_S], stack_pop_data[FLAG_V],
                          stack_pop_data[FLAG_D], stack_pop_data[FLAG_H]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cond_bits_r <= COND_RESET;
      end else begin
         cond_bits_r <= cond_bits_nxt;
      end
   end

   // User bits ignore the execution result entirely
   assign user_one_set = user_bit_we && !user_bit_sel;
   assign user_two_set = user_bit_we && user_bit_sel;

   always_comb begin
      user_one_nxt = user_one_r;
      user_two_nxt = user_two_r;
      if (user_one_set) begin
         user_one_nxt = user_bit_val;
      end
      if (user_two_set) begin
         user_two_nxt = user_bit_val;
      end
      if (sw_flags_wr) begin
         user_one_nxt = reg_wdata[FLAG_U1];
         user_two_nxt = reg_wdata[FLAG_U2];
      end
      if (interrupt_return_instruction) begin
         user_one_nxt = stack_pop_data[FLAG_U1];
         user_two_nxt = stack_pop_data[FLAG_U2];
      end
      // Nothing executes while reset is held, so every request is dropped;
      // a stray strobe during reset would otherwise alter the bits
      if (rst) begin
         user_one_nxt = user_one_r;
         user_two_nxt = user_two_r;
      end
   end

   // No reset branch: these bits keep their value through reset and
   // start undefined at power-up, so software must set them before use.
   always_ff @(posedge ref_clk) begin
      user_one_r <= user_one_nxt;
      user_two_r <= user_two_nxt;
   end

   // Save on exception entry; interrupt has priority in the cause code
   // Data hold after the pulse; the cause falls back to none with valid
   assign save_any   = save_irq || save_trap || save_illegal;
   assign save_cause = save_irq  ? CAUSE_IRQ :
                       save_trap ? CAUSE_TRAP :
                       save_illegal ? CAUSE_ILLEGAL : CAUSE_NONE;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         push_valid_r <= 1'b0;
         push_data_r  <= 8'h00;
         push_cause_r <= CAUSE_NONE;
      end else begin
         push_valid_r <= save_any;
         push_cause_r <= save_cause;
         if (save_any) begin
            push_data_r <= flags_now;
         end
      end
   end

   // Condition query: a first-map relative or absolute jump opcode on the stream supplies its own field
   // The jump field wins, so a jump needs no separate cond_code set-up
   assign is_cc_jump = op_valid && (map_r == CSFOD_MAP_FIRST) &&
                       ((op_byte[3:0] == COL_REL_JUMP) || (op_byte[3:0] == COL_ABS_JUMP));
   assign cc_select  = is_cc_jump ? op_byte[7:4] : cond_code;

   assign cond_bus.code  = cc_select;
   assign cond_bus.flags = flags_now;

   csfod_cond_eval u_cond_eval (
      .ref_clk (ref_clk),
      .rst     (rst),
      .cond    (cond_bus.evaluator)
   );

   // Opcode decode by row and column
   always_comb begin
      map_nxt         = map_r;
      class_nxt       = class_r;
      dec_uses_cc_nxt = 1'b0;
      if (op_valid) begin
         case (map_r)
            CSFOD_MAP_FIRST: begin
               dec_uses_cc_nxt = is_cc_jump;
               case (op_byte)
                  OP_BREAKPOINT: class_nxt = CSFOD_DEC_BREAKPOINT;
                  OP_NO_OP:      class_nxt = CSFOD_DEC_NO_OP;
                  OP_ATOMIC:     class_nxt = CSFOD_DEC_ATOMIC;
                  OP_WATCHDOG:   class_nxt = CSFOD_DEC_WATCHDOG;
                  OP_STOP:       class_nxt = CSFOD_DEC_STOP;
                  OP_HALT:       class_nxt = CSFOD_DEC_HALT;
                  OP_ESCAPE: begin
                     class_nxt = CSFOD_DEC_ESCAPE;
                     map_nxt   = CSFOD_MAP_SECOND;
                  end
                  default:       class_nxt = CSFOD_DEC_OTHER;
               endcase
            end
            CSFOD_MAP_SECOND: begin
               class_nxt = CSFOD_DEC_MAP2;
               map_nxt   = CSFOD_MAP_FIRST;
            end
            default: begin
               class_nxt = CSFOD_DEC_NONE;
               map_nxt   = CSFOD_MAP_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         map_r <= CSFOD_MAP_FIRST;
      end else begin
         map_r <= map_nxt;
      end
   end

   // Decode outputs hold until the next byte; valid is a one-cycle pulse
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         class_r       <= CSFOD_DEC_NONE;
         dec_valid_r   <= 1'b0;
         dec_row_r     <= 4'h0;
         dec_col_r     <= 4'h0;
         dec_second_r  <= 1'b0;
         dec_uses_cc_r <= 1'b0;
         last_op_r     <= 8'h00;
      end else begin
         class_r     <= class_nxt;
         dec_valid_r <= op_valid;
         if (op_valid) begin
            dec_row_r     <= op_byte[7:4];
            dec_col_r     <= op_byte[3:0];
            dec_second_r  <= (map_r == CSFOD_MAP_SECOND);
            dec_uses_cc_r <= dec_uses_cc_nxt;
            last_op_r     <= op_byte;
         end
      end
   end

   // Sign-extend the displacement so the branch adder can add it directly
   assign disp_nxt = {{(DISP_W-8){disp_byte[7]}}, disp_byte};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         disp_valid_r <= 1'b0;
         disp_r       <= '0;
      end else begin
         disp_valid_r <= disp_valid;
         if (disp_valid) begin
            disp_r <= disp_nxt;
         end
      end
   end

   // Register read port; data stand only in the cycle after the strobe
   always_comb begin
      reg_rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            REG_FLAGS:   reg_rdata_nxt = flags_now;
            REG_DECODE:  reg_rdata_nxt = {(map_r == CSFOD_MAP_SECOND), 3'h0, class_r};
            REG_LAST_OP: reg_rdata_nxt = last_op_r;
            default:     reg_rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else begin
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   assign reg_rdata        = reg_rdata_r;
   assign stack_push_valid = push_valid_r;
   assign stack_push_data  = push_data_r;
   assign stack_push_cause = push_cause_r;
   assign cond_true        = cond_bus.result;
   assign flags            = {cond_bits_r[5:2], cond_bits_r[1:0], user_two_r, user_one_r};
   assign dec_valid        = dec_valid_r;
   assign dec_row          = dec_row_r;
   assign dec_col          = dec_col_r;
   assign dec_class        = class_r;
   assign dec_second_map   = dec_second_r;
   assign dec_uses_cc      = dec_uses_cc_r;
   assign disp_out_valid   = disp_valid_r;
   assign disp_out         = disp_r;

endmodule
`default_nettype wire

// [csfod_core_sva.sv]
// Concurrent checks on the ports of the status flags and opcode decode core.
// Assumes a single clock ref_clk and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module csfod_core_sva
   import csfod_pkg::*;
#(
   parameter int unsigned DISP_W = 16
)(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [3:0]        reg_addr,
   input wire logic              reg_wr,
   input wire logic              alu_flag_we,
   input wire logic [5:0]        alu_flag_mask,
   input wire logic [5:0]        alu_flag_val,
   input wire logic              user_bit_we,
   input wire logic              save_irq,
   input wire logic              save_trap,
   input wire logic              save_illegal,
   input wire logic              stack_push_valid,
   input wire logic [7:0]        stack_push_data,
   input wire logic [1:0]        stack_push_cause,
   input wire logic              interrupt_return_instruction,
   input wire logic [7:0]        stack_pop_data,
   input wire logic [3:0]        cond_code,
   input wire logic              cond_true,
   input wire logic              op_valid,
   input wire logic [7:0]        op_byte,
   input wire logic [7:0]        flags,
   input wire logic              dec_valid,
   input wire logic [3:0]        dec_row,
   input wire logic [3:0]        dec_col,
   input wire logic [3:0]        dec_class,
   input wire logic              dec_second_map,
   input wire logic              disp_valid,
   input wire logic [7:0]        disp_byte,
   input wire logic              disp_out_valid,
   input wire logic [DISP_W-1:0] disp_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // User bits power up undefined, so their checks wait for a first write
   logic armed_r = 1'b0;
   wire  flag_wr = reg_wr && (reg_addr == REG_FLAGS);
   wire  any_save = save_irq || save_trap || save_illegal;
   always @(posedge ref_clk) armed_r <= armed_r | (flag_wr & ~rst);
   function automatic logic cc_eval(logic [3:0] c, logic [7:0] f);
      logic [7:0] t;
      t = {f[FLAG_C], f[FLAG_Z], f[FLAG_S], f[FLAG_V], f[FLAG_C] | f[FLAG_Z],
           f[FLAG_Z] | (f[FLAG_S] ^ f[FLAG_V]), f[FLAG_S] ^ f[FLAG_V], 1'b0};
      return t[c[2:0]] ^ c[3];
   endfunction
   chk_alu_masked_update: assert property (
      alu_flag_we && !flag_wr && !interrupt_return_instruction
      |=> flags[7:2] == (($past(flags[7:2]) & ~$past(alu_flag_mask))
                        | ($past(alu_flag_val) & $past(alu_flag_mask))))
      else $error("flag bits differ from masked alu update");
   chk_user_bits_hold: assert property (
      armed_r && !user_bit_we && !flag_wr
      && !interrupt_return_instruction |=> $stable(flags[1:0]))
      else $error("user bits changed without explicit request");
   chk_reset_keeps_user: assert property (
      disable iff (1'b0) armed_r && rst |=> flags[1:0] == $past(flags[1:0]))
      else $error("reset altered user bits");
   chk_push_on_save: assert property (
      any_save |=> stack_push_valid
      && stack_push_data == $past(flags) && stack_push_cause == ($past(save_irq) ? CAUSE_IRQ
      : $past(save_trap) ? CAUSE_TRAP : CAUSE_ILLEGAL))
      else $error("save did not push flags with its cause");
   chk_no_push_idle: assert property (
      !any_save |=> !stack_push_valid && stack_push_cause == CAUSE_NONE)
      else $error("push without a save request");
   chk_restore_flags: assert property (
      interrupt_return_instruction |=> flags == $past(stack_pop_data))
      else $error("return did not reload stacked flags");
   chk_cond_eval: assert property (
      !op_valid |=> cond_true == cc_eval($past(cond_code), $past(flags)))
      else $error("condition result wrong");
   chk_disp_sign_ext: assert property (
      disp_valid |=> disp_out_valid
      && disp_out == {{(DISP_W-8){$past(disp_byte[7])}}, $past(disp_byte)})
      else $error("displacement not sign extended");
   chk_row_col_split: assert property (
      op_valid |=> dec_valid
      && dec_row == $past(op_byte[7:4]) && dec_col == $past(op_byte[3:0]))
      else $error("opcode nibbles not decoded");
   // Escape class holds until the next byte, so gaps after the escape are allowed
   chk_escape_second_map: assert property (
      op_valid && dec_class == CSFOD_DEC_ESCAPE
      |=> dec_second_map && dec_class == CSFOD_DEC_MAP2)
      else $error("byte after escape not in second map");
   cov_trap: cover property (save_trap ##1 stack_push_valid);
   cov_restore: cover property (interrupt_return_instruction);
   cov_escape: cover property (dec_second_map);
   cov_neg_disp: cover property (disp_valid && disp_byte[7]);
endmodule
bind csfod_core csfod_core_sva #(.DISP_W(DISP_W)) i_csfod_core_sva (.*);
`default_nettype wire

// [csfod_tb_top.sv]
// Self-checking bench for the status flags and opcode decode core.
// Drives every core input itself; a small integer model gives expectations.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module csfod_tb_top
   import csfod_pkg::*;
;
   logic ref_clk, rst, reg_wr, reg_rd, alu_flag_we, user_bit_we, user_bit_sel, user_bit_val;
   logic save_irq, save_trap, save_illegal, interrupt_return_instruction, op_valid, disp_valid;
   logic [3:0] reg_addr, cond_code, dec_row, dec_col, dec_class;
   logic [7:0] reg_wdata, stack_pop_data, op_byte, disp_byte, reg_rdata, stack_push_data, flags;
   logic [5:0] alu_flag_mask, alu_flag_val;
   logic [1:0] stack_push_cause;
   logic stack_push_valid, cond_true, dec_valid, dec_second_map, dec_uses_cc, disp_out_valid;
   logic [15:0] disp_out;
   logic [7:0] d;
   int num_errors = 0, n_compared = 0, cyc = 0, seed = 54848;
   int mf, m, v, c, e, k, b, sec;
   int ops[$] = '{8'h00, 8'h0F, 8'h2F, 8'h5F, 8'h6F, 8'h7F, 8'h6B, 8'h3D, 8'h1F, 8'h1F, 8'h7F};
   int cls[$] = '{2, 3, 4, 5, 6, 7, 1, 1, 8, 9, 7};
   int pats[4] = '{4, 2, 1, 7};
   int caus[4] = '{1, 2, 3, 1};
   int dsp[5] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'h35};
   csfod_core #(.DISP_W(16)) i_csfod_core (.*);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         stop_test();
      end
   end
   function automatic bit cm(int cc, int f);
      bit [7:0] t;
      t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
      return t[cc & 7] ^ cc[3];
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] dt);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= dt;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] dt);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 dt = reg_rdata;
   endtask
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {ref_clk, reg_wr, reg_rd, alu_flag_we, user_bit_we, user_bit_sel, user_bit_val} = '0;
      {save_irq, save_trap, save_illegal, interrupt_return_instruction, op_valid} = '0;
      {disp_valid, reg_addr, cond_code, reg_wdata, stack_pop_data, op_byte, disp_byte} = '0;
      {alu_flag_mask, alu_flag_val} = '0;
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rd(REG_FLAGS, d); `CHK(d[7:2], 6'h00)
      rd(4'hF, d); `CHK(d, 8'h00)
      wr(REG_FLAGS, 8'hA5); mf = 8'hA5;
      rd(REG_FLAGS, d); `CHK(d, 8'hA5)
      $display("reset and register test done");
      repeat (20) begin
         m = $random(seed) & 63; v = $random(seed) & m;
         @(posedge ref_clk);
         alu_flag_we <= 1'b1; alu_flag_mask <= m[5:0]; alu_flag_val <= v[5:0];
         @(posedge ref_clk);
         alu_flag_we <= 1'b0;
         #1 mf = (mf & ~(m << 2)) | (v << 2);
         `CHK(flags, 8'(mf))
      end
      for (k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         user_bit_we <= 1'b1; user_bit_sel <= k[1]; user_bit_val <= ~k[0];
         @(posedge ref_clk);
         user_bit_we <= 1'b0;
         #1 mf[k[1]] = ~k[0];
         `CHK(flags, 8'(mf))
      end
      $display("flag update test done");
      repeat (6) begin
         mf = $random(seed) & 255;
         wr(REG_FLAGS, 8'(mf));
         for (c = 0; c < 16; c++) begin
            @(posedge ref_clk);
            cond_code <= c[3:0];
            @(posedge ref_clk);
            #1 `CHK(cond_true, cm(c, mf))
         end
      end
      $display("condition test done");
      for (k = 0; k < 4; k++) begin
         mf = $random(seed) & 255;
         wr(REG_FLAGS, 8'(mf));
         @(posedge ref_clk);
         {save_irq, save_trap, save_illegal} <= 3'(pats[k]);
         @(posedge ref_clk);
         {save_irq, save_trap, save_illegal} <= 3'h0;
         #1 `CHK({stack_push_valid, stack_push_data}, {1'b1, 8'(mf)})
         `CHK(stack_push_cause, 2'(caus[k]))
      end
      // Restore must win over an alu update in the same cycle
      mf = $random(seed) & 255;
      @(posedge ref_clk);
      interrupt_return_instruction <= 1'b1; stack_pop_data <= 8'(mf);
      alu_flag_we <= 1'b1; alu_flag_mask <= 6'h3F; alu_flag_val <= ~mf[7:2];
      @(posedge ref_clk);
      interrupt_return_instruction <= 1'b0; alu_flag_we <= 1'b0;
      #1 `CHK(flags, 8'(mf))
      $display("save and restore test done");
      for (k = 0; k < 5; k++) begin
         @(posedge ref_clk);
         disp_valid <= 1'b1; disp_byte <= 8'(dsp[k]);
         @(posedge ref_clk);
         disp_valid <= 1'b0;
         e = (dsp[k] > 127) ? dsp[k] - 256 : dsp[k];
         #1 `CHK({disp_out_valid, disp_out}, {1'b1, 16'(e)})
      end
      $display("displacement test done");
      sec = 0;
      foreach (ops[i]) begin
         @(posedge ref_clk);
         op_valid <= 1'b1; op_byte <= 8'(ops[i]); cond_code <= 4'h0;
         @(posedge ref_clk);
         op_valid <= 1'b0;
         b = ops[i] & 15;
         #1 `CHK({dec_valid, dec_row, dec_col}, {1'b1, 8'(ops[i])})
         `CHK({dec_class, dec_second_map}, {4'(cls[i]), 1'(sec)})
         `CHK(dec_uses_cc, 1'(sec == 0 && (b == 11 || b == 13)))
         `CHK(cond_true, cm((sec == 0 && (b == 11 || b == 13)) ? ops[i] >> 4 : 0, mf))
         sec = (sec == 0 && ops[i] == 8'h1F) ? 1 : 0;
      end
      rd(REG_LAST_OP, d); `CHK(d, 8'(ops[$]))
      rd(REG_DECODE, d); `CHK(d, 8'h07)
      $display("opcode decode test done");
      wr(REG_FLAGS, 8'hF2);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      // A user-bit strobe inside reset must not reach the bits
      user_bit_we <= 1'b1;
      user_bit_sel <= 1'b0;
      user_bit_val <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      user_bit_we <= 1'b0;
      #1 `CHK(flags, 8'h02)
      $display("mid-run reset test done");
      stop_test();
   end
endmodule
`default_nettype wire
